// ===== include/startup_pkg.sv
// constants and types shared by the reset/clock start-up sequencer
// assumes a single 100 MHz system clock standing in for the oscillator
package startup_pkg;
  // one oscillator period modelled as one clk cycle; a state time is two
  localparam int unsigned OSC_PER_STATE = 2;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // least reset hold, in state times, and its count in clk cycles
  localparam int unsigned RESET_HOLD_STATES = 4;
  localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_STATES * OSC_PER_STATE;
  // length of the post-reset sequence, in state times
  localparam logic [3:0] INIT_STATES = 4'h000A;
  // fixed addresses used by the sequence
  localparam logic [15:0] CONFIG_BYTE_ADDR = 16'h2018;
  localparam logic [15:0] START_VECTOR = 16'h2080;
  // reset values
  localparam logic [15:0] STATUS_WORD_RESET = 16'h0000;
  localparam logic [7:0] CONFIG_BYTE_RESET = 8'h00;
  // configuration byte bit that enables dynamic bus width
  localparam int unsigned CFG_BUSWIDTH_BIT = 1;
  // state times at which the sequence clears status and fetches config
  localparam logic [3:0] STEP_CLEAR_STATUS = 4'h0001;
  localparam logic [3:0] STEP_FETCH_CONFIG = 4'h0003;

  typedef enum logic [3:0] {
    SEQ_RESET = 4'b0001,
    SEQ_INIT = 4'b0010,
    SEQ_JUMP = 4'b0100,
    SEQ_RUN = 4'b1000
  } seq_state_t;
endpackage

// ===== include/clock_phase_if.sv
// divided clock state shared between the sequencer and its divider
// assumes both ends sit on clk
`timescale 1ns/1ns
interface clock_phase_if;
  logic restartPhase;
  logic divClock;
  logic stateTick;
  modport divider (input restartPhase, output divClock, output stateTick);
  modport user (output restartPhase, input divClock, input stateTick);
endinterface

// ===== verilog/clock_divider.sv
// divide-by-two clock generator with phase restart
// assumes clk is the oscillator and restart comes from clk logic
`timescale 1ns/1ns
module clock_divider
  import startup_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  clock_phase_if.divider phase
);
  logic divClock_reg;
  logic divClock_next;

  // toggle every oscillator cycle, restart low on reset release
  always_comb begin
    if (phase.restartPhase) begin
      divClock_next = 1'b0; // R04
    end else begin
      divClock_next = ~divClock_reg; // R01 R02
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      divClock_reg <= 1'b0;
    end else begin
      divClock_reg <= divClock_next;
    end
  end

  assign phase.divClock = divClock_reg;
  // one state time ends as the divided clock falls
  assign phase.stateTick = divClock_reg; // R11

  AST_HALF_RATE: assert property (@(posedge clk) disable iff (!reset_n)
    $past(reset_n) && !$past(phase.restartPhase) && !phase.restartPhase
    |-> divClock_reg != $past(divClock_reg)) // R01
    else $error("divided clock failed to toggle");
  AST_SYMMETRIC: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(divClock_reg) && !phase.restartPhase |=> !divClock_reg) // R02
    else $error("divided clock high not one cycle");
endmodule

// ===== verilog/reset_clock_startup_sequencer.sv
// reset and clock start-up sequencer with bus width selection
// assumes clk is the oscillator; reset and bus width pins are asynchronous
`timescale 1ns/1ns
// Summary of operation
// R01 - the clock output runs at half the oscillator rate.
// R02 - the clock output is high and low for equal times.
// R03 - the board holds reset low for at least four state times.
// R04 - the release of reset restarts the phase of the clock output.
// R05 - after release a ten state time sequence precedes execution.
// R06 - the sequence clears the status word and loads the config byte.
// R07 - the sequence ends with a jump to the fixed start address.
// R08 - the device runs only while reset is held high.
// R09 - with config bit 1 set the width pin picks 16 or 8 bits per cycle.
// R10 - with config bit 1 clear every bus cycle is 8 bits wide.
// R11 - one state time is two oscillator periods.
module reset_clock_startup_sequencer
  import startup_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic resetPin_n,
  input wire logic busWidthPin,
  input wire logic busCycleStart,
  input wire logic configFetchValid,
  input wire logic [7:0] configFetchData,
  output logic divided_clock_output,
  output logic configFetchReq,
  output logic [15:0] configFetchAddr,
  output logic [15:0] processor_status_word,
  output logic [7:0] chip_config_byte,
  output logic [15:0] startAddress,
  output logic startStrobe,
  output logic cpuRunning,
  output logic busWide
);
  clock_phase_if phase ();
  seq_state_t state_reg, state_next;
  logic [1:0] pinSync_reg, pinSync_next;
  logic [1:0] widthSync_reg, widthSync_next;
  logic [3:0] stateCount_reg, stateCount_next;
  logic [15:0] status_reg, status_next;
  logic [7:0] config_reg, config_next;
  logic fetchReq_reg, fetchReq_next;
  logic start_reg, start_next;
  logic wide_reg, wide_next;
  logic pinHigh;

  clock_divider divider (
    .clk(clk),
    .reset_n(reset_n),
    .phase(phase)
  );

  // two-flop synchronisers for the reset and width pins
  always_comb begin
    pinSync_next = {pinSync_reg[0], resetPin_n};
    widthSync_next = {widthSync_reg[0], busWidthPin};
  end
  assign pinHigh = pinSync_reg[1];

  // sequence state and counters
  always_comb begin
    state_next = state_reg;
    stateCount_next = stateCount_reg;
    status_next = status_reg;
    config_next = config_reg;
    fetchReq_next = fetchReq_reg;
    start_next = 1'b0;
    phase.restartPhase = 1'b0;
    if (!pinHigh) begin
      state_next = SEQ_RESET; // R08
      stateCount_next = 4'h0000;
      fetchReq_next = 1'b0;
    end else begin
      case (state_reg)
        SEQ_RESET: begin
          phase.restartPhase = 1'b1; // R04
          state_next = SEQ_INIT;
          stateCount_next = 4'h0000;
        end
        SEQ_INIT: begin
          if (phase.stateTick) begin
            stateCount_next = stateCount_reg + 4'h0001; // R11
            if (stateCount_next == STEP_CLEAR_STATUS) begin
              status_next = STATUS_WORD_RESET; // R06
            end
            if (stateCount_next == STEP_FETCH_CONFIG) begin
              fetchReq_next = 1'b1; // R06
            end
            if (stateCount_next == INIT_STATES - 4'h0001) begin
              state_next = SEQ_JUMP; // R05
            end
          end
          if (fetchReq_reg && configFetchValid) begin
            config_next = configFetchData; // R06
            fetchReq_next = 1'b0;
          end
        end
        SEQ_JUMP: begin
          if (phase.stateTick) begin
            stateCount_next = INIT_STATES;
            state_next = SEQ_RUN;
            start_next = 1'b1; // R07
            fetchReq_next = 1'b0;
          end
        end
        SEQ_RUN: begin
          state_next = SEQ_RUN;
        end
        default: begin
          state_next = SEQ_RESET;
        end
      endcase
    end
  end

  // bus width latched at the start of each bus cycle
  always_comb begin
    wide_next = wide_reg;
    if (busCycleStart) begin
      if (config_reg[CFG_BUSWIDTH_BIT]) begin
        wide_next = widthSync_reg[1]; // R09
      end else begin
        wide_next = 1'b0; // R10
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinSync_reg <= 2'h0;
      widthSync_reg <= 2'h0;
      state_reg <= SEQ_RESET;
      stateCount_reg <= 4'h0000;
      status_reg <= STATUS_WORD_RESET;
      config_reg <= CONFIG_BYTE_RESET;
      fetchReq_reg <= 1'b0;
      start_reg <= 1'b0;
      wide_reg <= 1'b0;
    end else begin
      pinSync_reg <= pinSync_next;
      widthSync_reg <= widthSync_next;
      state_reg <= state_next;
      stateCount_reg <= stateCount_next;
      status_reg <= status_next;
      config_reg <= config_next;
      fetchReq_reg <= fetchReq_next;
      start_reg <= start_next;
      wide_reg <= wide_next;
    end
  end

  // outputs
  assign divided_clock_output = phase.divClock;
  assign configFetchReq = fetchReq_reg;
  assign configFetchAddr = CONFIG_BYTE_ADDR;
  assign processor_status_word = status_reg;
  assign chip_config_byte = config_reg;
  assign startAddress = START_VECTOR; // R07
  assign startStrobe = start_reg;
  assign cpuRunning = (state_reg == SEQ_RUN);
  assign busWide = wide_reg;

  AST_RESTART_LOW: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == SEQ_RESET && pinHigh |=> !divided_clock_output) // R04
    else $error("clock phase not restarted at reset release");
  AST_TEN_STATES: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == SEQ_RESET && pinHigh |=> !cpuRunning [*8] ##12 !cpuRunning
    ##1 cpuRunning) // R05
    else $error("start-up sequence length wrong");
  AST_NO_RUN_IN_RESET: assert property (@(posedge clk) disable iff (!reset_n)
    !pinHigh |=> !cpuRunning) // R08
    else $error("running while reset held");
  AST_JUMP: assert property (@(posedge clk) disable iff (!reset_n)
    startStrobe |-> cpuRunning && startAddress == START_VECTOR) // R07
    else $error("start strobe without run");
  AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(cpuRunning) |-> processor_status_word == STATUS_WORD_RESET) // R06
    else $error("status word not cleared");
  AST_NARROW: assert property (@(posedge clk) disable iff (!reset_n)
    busCycleStart && !chip_config_byte[CFG_BUSWIDTH_BIT] |=> !busWide) // R10
    else $error("wide cycle with dynamic width off");
  AST_DYNAMIC: assert property (@(posedge clk) disable iff (!reset_n)
    busCycleStart && chip_config_byte[CFG_BUSWIDTH_BIT]
    |=> busWide == $past(widthSync_reg[1])) // R09
    else $error("bus width not taken from pin");
  AST_WIDTH_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !busCycleStart |=> busWide == $past(busWide)) // R09
    else $error("bus width changed outside a cycle start");

  // state time counting, one step per divided clock period
  AST_COUNT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == SEQ_INIT && pinHigh && !phase.stateTick
    |=> stateCount_reg == $past(stateCount_reg)) // R11
    else $error("state count moved without a tick");
  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == SEQ_INIT && pinHigh && phase.stateTick
    |=> stateCount_reg == $past(stateCount_reg) + 4'h1) // R11
    else $error("state count missed a tick");

  // config fetch raised at its step, taken once, gone before running
  AST_FETCH_STEP: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(configFetchReq) |-> stateCount_reg == STEP_FETCH_CONFIG) // R06
    else $error("config fetch raised at wrong step");
  AST_CONFIG_TAKEN: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == SEQ_INIT && pinHigh && configFetchReq && configFetchValid
    |=> chip_config_byte == $past(configFetchData) && !configFetchReq) // R06
    else $error("config byte not taken from fetch");
  AST_REQ_ENDS: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == SEQ_RUN |-> !configFetchReq) // R06
    else $error("config fetch still pending while running");

  // jump and run behaviour around the end of the sequence
  AST_JUMP_STEP: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg == SEQ_JUMP && pinHigh && phase.stateTick
    |=> startStrobe && cpuRunning) // R07
    else $error("jump not taken at end of sequence");
  AST_STROBE_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
    startStrobe |=> !startStrobe) // R07
    else $error("start strobe longer than one cycle");
  AST_RUN_STAYS: assert property (@(posedge clk) disable iff (!reset_n)
    cpuRunning && pinHigh |=> cpuRunning) // R08
    else $error("stopped running with reset high");
  AST_RELEASE_FROM_RESET: assert property (@(posedge clk)
    disable iff (!reset_n)
    $rose(pinHigh) |-> state_reg == SEQ_RESET) // R08
    else $error("reset release seen outside the reset state");
endmodule

// ===== verif/config_memory_model.sv
// memory model that answers the start-up configuration byte fetch
// assumes the fetch request is a level held until the valid pulse
`timescale 1ns/1ns
module config_memory_model
  import startup_pkg::*;
(
  input wire logic clk,
  input wire logic configFetchReq,
  input wire logic [15:0] configFetchAddr,
  input wire logic [7:0] storedByte,
  input wire logic [3:0] latency,
  output logic configFetchValid,
  output logic [7:0] configFetchData
);
  logic [3:0] waitCount;
  initial begin
    configFetchValid = 1'b0;
    configFetchData = 8'h00;
    waitCount = 4'h0;
  end
  // answer after latency cycles; idle data keeps changing
  always @(posedge clk) begin
    #1;
    if (configFetchReq && !configFetchValid && waitCount == latency) begin
      configFetchValid <= 1'b1;
      // only the fixed address returns the stored byte
      configFetchData <= (configFetchAddr === CONFIG_BYTE_ADDR) ?
        storedByte : ~storedByte;
    end else begin
      configFetchValid <= 1'b0;
      configFetchData <= ~configFetchData;
    end
    if (configFetchReq && !configFetchValid && waitCount != latency) begin
      waitCount <= waitCount + 4'h1;
    end else begin
      waitCount <= 4'h0;
    end
  end
endmodule

// ===== verif/reset_clock_startup_sequencer_tb.sv
// testbench for the reset and clock start-up sequencer
// assumes the memory model above answers the configuration fetch
`timescale 1ns/1ns
module reset_clock_startup_sequencer_tb;
  import startup_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, resetPin_n = 1'b0;
  logic busWidthPin = 1'b0, busCycleStart = 1'b0;
  logic configFetchValid, configFetchReq, divided_clock_output;
  logic startStrobe, cpuRunning, busWide;
  logic [7:0] configFetchData, chip_config_byte, storedByte = 8'h00;
  logic [15:0] configFetchAddr, processor_status_word, startAddress;
  logic [3:0] latency = 4'h1;
  int badCount = 0, compares = 0, n1, n2;
  always #5 clk = ~clk;
  reset_clock_startup_sequencer i_dut (.clk(clk), .reset_n(reset_n),
    .resetPin_n(resetPin_n), .busWidthPin(busWidthPin),
    .busCycleStart(busCycleStart), .configFetchValid(configFetchValid),
    .configFetchData(configFetchData),
    .divided_clock_output(divided_clock_output),
    .configFetchReq(configFetchReq), .configFetchAddr(configFetchAddr),
    .processor_status_word(processor_status_word),
    .chip_config_byte(chip_config_byte), .startAddress(startAddress),
    .startStrobe(startStrobe), .cpuRunning(cpuRunning), .busWide(busWide));
  config_memory_model i_mem (.clk(clk), .configFetchReq(configFetchReq),
    .configFetchAddr(configFetchAddr), .storedByte(storedByte),
    .latency(latency), .configFetchValid(configFetchValid),
    .configFetchData(configFetchData));
  // compare one value and count it
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // pulse the board reset, release at a chosen clock phase, run to start
  task automatic boot(input logic [7:0] cfg, input logic [3:0] lat,
                      input logic ph, output int n);
    n = 0;
    storedByte = cfg;
    latency = lat;
    resetPin_n = 1'b0;
    repeat (RESET_HOLD_CYCLES) @(posedge clk);
    #1 check("running in reset", 16'h0000, {15'h0, cpuRunning});
    for (int i = 0; i < 4 && divided_clock_output !== ph; i++)
      @(posedge clk) #1;
    resetPin_n = 1'b1;
    while (startStrobe !== 1'b1 && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    // two sync flops and the restart cycle precede the ten state times
    check("start latency", 16'(3 + INIT_STATES * OSC_PER_STATE),
          16'(n));
    check("start address", START_VECTOR, startAddress);
    check("status word", STATUS_WORD_RESET, processor_status_word);
    check("config byte", {8'h00, cfg}, {8'h00, chip_config_byte});
    check("fetch address", CONFIG_BYTE_ADDR, configFetchAddr);
    @(posedge clk) #1;
    check("strobe length", 16'h0000, {15'h0, startStrobe});
    check("running", 16'h0001, {15'h0, cpuRunning});
    $display("boot test done, %0d cycles", n);
  endtask
  // one bus cycle with the width pin at a given level
  task automatic width_case(input logic pin, input logic expWide);
    busWidthPin = pin;
    repeat (3) @(posedge clk) #1;
    busCycleStart = 1'b1;
    @(posedge clk) #1 busCycleStart = 1'b0;
    repeat (2) @(posedge clk) #1;
    check("bus width", {15'h0, expWide}, {15'h0, busWide});
    $display("width test done");
  endtask
  // clock output toggles every oscillator cycle, half of the time high
  task automatic divider_case();
    int highs;
    logic last;
    highs = 0;
    last = divided_clock_output;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) #1;
      check("clock toggle", {15'h0, ~last},
            {15'h0, divided_clock_output});
      last = divided_clock_output;
      highs += (divided_clock_output === 1'b1);
    end
    check("clock duty", 16'h0004, 16'(highs));
    $display("divider test done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    badCount++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    boot(8'h02, 4'h1, 1'b1, n1);
    divider_case();
    width_case(1'b0, 1'b0);
    // leave the bus wide so the narrow check below can trip
    width_case(1'b1, 1'b1);
    boot(8'h00, 4'h5, 1'b0, n2);
    check("phase restart", 16'(n1), 16'(n2));
    width_case(1'b1, 1'b0);
    tally_and_finish();
  end
endmodule
